//--- pkg/led_scan_pkg.sv
// Shared constants and carriers for the LED matrix scan and glyph control block.
// Assumes register accesses arrive already decoded from the two-wire serial slave.
package led_scan_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_NULL_WRITE = 8'h00;
    localparam logic [7:0] ADDR_BRIGHT_LOW = 8'h01;
    localparam logic [7:0] ADDR_BRIGHT_HIGH = 8'h02;
    localparam logic [7:0] ADDR_DIGIT_PAIR_COUNT = 8'h03;
    localparam logic [7:0] ADDR_GLYPH_DATA = 8'h05;
    localparam logic [7:0] ADDR_DISPLAY_TEST = 8'h07;
    // Reset values
    localparam logic [7:0] RST_BRIGHT = 8'h00;
    localparam logic [7:0] RST_DIGIT_PAIR_COUNT = 8'h00;
    localparam logic [7:0] RST_DISPLAY_TEST = 8'h00;
    localparam logic [6:0] RST_GLYPH_PTR = 7'h00;
    // Field positions
    localparam int SCAN_ALL_BIT = 0;
    localparam int TEST_BIT = 0;
    localparam int PTR_SET_BIT = 7;
    // Glyph memory layout
    localparam logic [7:0] GLYPH_PTR_FIRST = 8'h80;
    localparam logic [7:0] GLYPH_PTR_LAST = 8'hf7;
    localparam int GLYPH_COUNT = 24;
    localparam int GLYPH_COLS = 5;
    localparam int GLYPH_ENTRIES = 120;
    // Multiplex timing in multiplex clock ticks
    localparam int REFRESH_TICKS = 5600;
    localparam int ROWS = 7;
    localparam int PAIRS = 2;
    localparam int PWM_STEPS = 16;
    localparam int ROW_TICKS = REFRESH_TICKS / (PAIRS * ROWS);
    localparam int STEP_TICKS = ROW_TICKS / PWM_STEPS;
    localparam logic [3:0] MAX_ON_STEPS = 4'hf;
    localparam logic [4:0] TEST_ON_STEPS = 5'h07;
    localparam int TEST_SLOTS = 8;
    // Blink half periods with a 4 MHz multiplex clock
    localparam int MUX_CLOCK_HZ = 4000000;
    localparam int BLINK_FAST_HZ = 1;
    localparam int BLINK_HALF_FAST_TICKS = MUX_CLOCK_HZ / (2 * BLINK_FAST_HZ);

    typedef enum logic [0:0] {
        PAIR_LOW = 1'b0,
        PAIR_HIGH = 1'b1
    } pair_e;

    // Decoded register access from the serial slave
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_s;

    // Drive state handed to the row and column drivers
    typedef struct packed {
        logic [3:0] digit_on;
        logic [2:0] row;
        logic all_lit;
    } scan_out_s;
endpackage

//--- rtl/led_matrix_scan_font_control.sv
// Scan timing, PWM brightness, blink and user glyph RAM for a four-digit 5x7 driver.
// Assumes a decoded register port and a multiplex clock pin asynchronous to clk_i.
//
// Behaviour
// - User glyph n begins at pointer 0x80 plus five times n.
// - Digits 0 and 1 lit together, then digits 2 and 3.
// - Digit-pair count bit 0 selects one pair or both; other bits ignored.
// - Single pair scanned gives each digit twice the on-time.
// - Four independent modulators, one nibble each from two brightness registers.
// - Sixteen steps, 1/16 to 15/16, at least 1/16 blanked.
// - Null register write accepted and changes nothing.
// - Blink rates 1 Hz and 0.5 Hz divided from 4 MHz clock.
// - Display test lights everything, overriding but not altering registers.
// - Display test scans eight slots, lighting slots 0 to 3 at fixed 7/16 duty and blanking 4 to 7.
// - Data write stores seven bits at pointer then advances pointer.
// - Entry n sits at pointer 0x80 plus n; stored MSB reads zero.
// - Access at pointer 0xF7 wraps pointer back to 0x80.
// - Full four-digit refresh lasts 5600 multiplex clock ticks.
// - Low nibble drives even digit, high nibble odd; n gives (n+1)/16, capped at 15/16.
// - Display-test register bit 0 selects test mode.
`timescale 1ns/1ps
`default_nettype none
module led_matrix_scan_font_control #(
    parameter int BLINK_HALF_TICKS = led_scan_pkg::BLINK_HALF_FAST_TICKS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire led_scan_pkg::reg_req_s req_i,
    input wire logic mux_clock_input_i,
    input wire logic blink_fast_i,
    input wire logic shutdown_i,
    input wire logic [4:0] glyph_sel_i,
    input wire logic [2:0] glyph_col_i,
    output logic [7:0] rdata_o,
    output logic [6:0] glyph_data_o,
    output led_scan_pkg::scan_out_s scan_o,
    output logic blink_o
);
    // Elaboration check on the blink divider
    if (BLINK_HALF_TICKS < 2 || BLINK_HALF_TICKS > 4194303)
    begin : g_bad_blink
        $error("BLINK_HALF_TICKS out of range");
    end

    logic [7:0] bright_low_ff;
    logic [7:0] bright_high_ff;
    logic [7:0] pair_count_ff;
    logic [7:0] test_ff;
    logic [6:0] ptr_ff;
    logic [6:0] nxt_ptr;
    logic [6:0] glyph_mem [0:led_scan_pkg::GLYPH_ENTRIES-1];
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic tick;
    logic [4:0] tick_cnt_ff;
    logic [3:0] step_ff;
    logic [2:0] row_ff;
    led_scan_pkg::pair_e pair_ff;
    logic [2:0] slot_ff;
    logic [22:0] blink_cnt_ff;
    logic blink_ff;
    logic glyph_wr;
    logic glyph_rd;
    logic step_end;
    logic row_end;
    logic test_mode;
    logic scan_all;
    logic [6:0] glyph_idx;
    logic [4:0] on_steps [0:3];
    logic [3:0] nxt_digit_on;
    logic [22:0] blink_limit;

    assign test_mode = test_ff[led_scan_pkg::TEST_BIT];
    assign scan_all = pair_count_ff[led_scan_pkg::SCAN_ALL_BIT];
    assign glyph_wr = req_i.wr && req_i.addr == led_scan_pkg::ADDR_GLYPH_DATA
        && !req_i.data[led_scan_pkg::PTR_SET_BIT];
    assign glyph_rd = req_i.rd && req_i.addr == led_scan_pkg::ADDR_GLYPH_DATA;

    // Control registers; null and unmapped writes fall through untouched
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bright_low_ff <= led_scan_pkg::RST_BRIGHT;
            bright_high_ff <= led_scan_pkg::RST_BRIGHT;
            pair_count_ff <= led_scan_pkg::RST_DIGIT_PAIR_COUNT;
            test_ff <= led_scan_pkg::RST_DISPLAY_TEST;
        end
        else if (req_i.wr)
        begin
            case (req_i.addr)
                led_scan_pkg::ADDR_BRIGHT_LOW: bright_low_ff <= req_i.data;
                led_scan_pkg::ADDR_BRIGHT_HIGH: bright_high_ff <= req_i.data;
                led_scan_pkg::ADDR_DIGIT_PAIR_COUNT: pair_count_ff <= req_i.data;
                led_scan_pkg::ADDR_DISPLAY_TEST: test_ff <= req_i.data;
                default: ;
            endcase
        end
    end

    // Pointer update after a set, or after a data read or write
    always_comb
    begin
        nxt_ptr = ptr_ff;
        if (req_i.wr && req_i.addr == led_scan_pkg::ADDR_GLYPH_DATA && req_i.data[led_scan_pkg::PTR_SET_BIT])
        begin
            if (req_i.data > led_scan_pkg::GLYPH_PTR_LAST)
                nxt_ptr = led_scan_pkg::GLYPH_PTR_FIRST[6:0];
            else
                nxt_ptr = req_i.data[6:0];
        end
        else if (glyph_wr || glyph_rd)
        begin
            if ({1'b1, ptr_ff} == led_scan_pkg::GLYPH_PTR_LAST)
                nxt_ptr = led_scan_pkg::GLYPH_PTR_FIRST[6:0];
            else
                nxt_ptr = ptr_ff + 7'h01;
        end
    end

    // Glyph pointer
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            ptr_ff <= led_scan_pkg::RST_GLYPH_PTR;
        else
            ptr_ff <= nxt_ptr;
    end

    // Glyph RAM write, entry index is pointer minus 0x80
    always_ff @(posedge clk_i)
    begin
        if (glyph_wr)
            glyph_mem[ptr_ff] <= req_i.data[6:0];
    end

    // Register read data, glyph entries read with MSB clear
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= 8'h00;
        else if (req_i.rd)
        begin
            case (req_i.addr)
                led_scan_pkg::ADDR_BRIGHT_LOW: rdata_o <= bright_low_ff;
                led_scan_pkg::ADDR_BRIGHT_HIGH: rdata_o <= bright_high_ff;
                led_scan_pkg::ADDR_DIGIT_PAIR_COUNT: rdata_o <= pair_count_ff;
                led_scan_pkg::ADDR_DISPLAY_TEST: rdata_o <= test_ff;
                led_scan_pkg::ADDR_GLYPH_DATA: rdata_o <= {1'b0, glyph_mem[ptr_ff]};
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // Renderer lookup: glyph n column c at base 0x80 + 5n + c
    // Widen before the product so glyphs 7 and up do not wrap
    assign glyph_idx = 7'(glyph_sel_i) * 7'd5 + 7'(glyph_col_i);
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            glyph_data_o <= 7'h00;
        else if (glyph_sel_i < 5'(led_scan_pkg::GLYPH_COUNT) && glyph_col_i < 3'(led_scan_pkg::GLYPH_COLS))
            glyph_data_o <= glyph_mem[glyph_idx];
        else
            glyph_data_o <= 7'h00;
    end

    // Multiplex clock pin synchroniser and rising edge
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= mux_clock_input_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    assign tick = sync2_ff && !sync3_ff;
    assign step_end = tick && tick_cnt_ff == 5'(led_scan_pkg::STEP_TICKS - 1);
    assign row_end = step_end && step_ff == 4'(led_scan_pkg::PWM_STEPS - 1);

    // Step timer: 25 ticks per step, 16 steps per 400-tick row slot
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tick_cnt_ff <= 5'h00;
            step_ff <= 4'h0;
        end
        else if (step_end)
        begin
            tick_cnt_ff <= 5'h00;
            step_ff <= step_ff + 4'h1;
        end
        else if (tick)
            tick_cnt_ff <= tick_cnt_ff + 5'h01;
    end

    // Row and pair sequencing; one pair alone doubles each digit's share
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            row_ff <= 3'h0;
            pair_ff <= led_scan_pkg::PAIR_LOW;
            slot_ff <= 3'h0;
        end
        else if (row_end)
        begin
            slot_ff <= slot_ff + 3'h1;
            if (test_mode)
                pair_ff <= led_scan_pkg::pair_e'(slot_ff[0] ^ 1'b1);
            else if (!scan_all)
                pair_ff <= led_scan_pkg::PAIR_LOW;
            else
                pair_ff <= (pair_ff == led_scan_pkg::PAIR_LOW) ? led_scan_pkg::PAIR_HIGH
                    : led_scan_pkg::PAIR_LOW;
            if (pair_ff == led_scan_pkg::PAIR_HIGH || !scan_all || test_mode)
                row_ff <= (row_ff == 3'(led_scan_pkg::ROWS - 1)) ? 3'h0 : row_ff + 3'h1;
        end
    end

    // Per-digit on-steps: nibble n gives n+1 steps, capped at 15
    always_comb
    begin
        on_steps[0] = {1'b0, bright_low_ff[3:0]} + 5'h01;
        on_steps[1] = {1'b0, bright_low_ff[7:4]} + 5'h01;
        on_steps[2] = {1'b0, bright_high_ff[3:0]} + 5'h01;
        on_steps[3] = {1'b0, bright_high_ff[7:4]} + 5'h01;
        nxt_digit_on = 4'h0;
        for (int d = 0; d < 4; d++)
        begin
            if (on_steps[d] > {1'b0, led_scan_pkg::MAX_ON_STEPS})
                on_steps[d] = {1'b0, led_scan_pkg::MAX_ON_STEPS};
            if (test_mode)
                nxt_digit_on[d] = !slot_ff[2] && (d / 2 == int'(pair_ff))
                    && {1'b0, step_ff} < led_scan_pkg::TEST_ON_STEPS;
            else
                nxt_digit_on[d] = !shutdown_i && (d / 2 == int'(pair_ff))
                    && {1'b0, step_ff} < on_steps[d];
        end
    end

    // Drive outputs registered
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            scan_o <= '0;
        else
        begin
            scan_o.digit_on <= nxt_digit_on;
            scan_o.row <= row_ff;
            scan_o.all_lit <= test_mode;
        end
    end

    // Blink divider on multiplex ticks, slow rate is twice the half period
    assign blink_limit = blink_fast_i ? 23'(BLINK_HALF_TICKS - 1) : 23'(2 * BLINK_HALF_TICKS - 1);
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            blink_cnt_ff <= 23'h000000;
            blink_ff <= 1'b1;
        end
        else if (tick)
        begin
            if (blink_cnt_ff >= blink_limit)
            begin
                blink_cnt_ff <= 23'h000000;
                blink_ff <= !blink_ff;
            end
            else
                blink_cnt_ff <= blink_cnt_ff + 23'h000001;
        end
    end
    assign blink_o = blink_ff;
endmodule
`default_nettype wire

//--- verif/led_scan_asserts.sv
// Port checker for the LED scan and glyph control block.
// Assumes it is bound onto every instance of led_matrix_scan_font_control.
`timescale 1ns/1ps
`default_nettype none
module led_scan_checker #(
    parameter int BLINK_HALF_TICKS = 20
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire led_scan_pkg::reg_req_s req_i,
    input wire logic mux_clock_input_i,
    input wire logic blink_fast_i,
    input wire logic shutdown_i,
    input wire logic [4:0] glyph_sel_i,
    input wire logic [2:0] glyph_col_i,
    input wire logic [7:0] rdata_o,
    input wire logic [6:0] glyph_data_o,
    input wire led_scan_pkg::scan_out_s scan_o,
    input wire logic blink_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Outputs in their idle state right after release
    a_reset_outputs: assert property ($fell(srst_i) |-> scan_o == '0 && blink_o && rdata_o == 8'h00)
        else $error("outputs not idle after reset");
    // Digit pairs never lit at once
    a_pairs_apart: assert property (!(|scan_o.digit_on[1:0] && |scan_o.digit_on[3:2]))
        else $error("both digit pairs lit");
    a_rdata_holds: assert property (!req_i.rd |=> $stable(rdata_o))
        else $error("read data moved without a read");
    a_glyph_msb_zero: assert property (req_i.rd && req_i.addr == 8'h05 |=> !rdata_o[7])
        else $error("glyph read with msb set");
    a_unmapped_zero: assert property (req_i.rd && req_i.addr == 8'h04 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_glyph_range: assert property (glyph_sel_i > 5'd23 || glyph_col_i > 3'd4 |=> glyph_data_o == 7'h00)
        else $error("out of range glyph lookup not zero");
    a_shutdown_dark: assert property (shutdown_i[*3] ##0 !scan_o.all_lit |-> scan_o.digit_on == 4'h0)
        else $error("digit lit in shutdown");
    a_blink_spacing: assert property ($changed(blink_o) |=> $stable(blink_o)[*8])
        else $error("blink toggled too soon");
endmodule
bind led_matrix_scan_font_control led_scan_checker #(.BLINK_HALF_TICKS(BLINK_HALF_TICKS)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .mux_clock_input_i(mux_clock_input_i),
    .blink_fast_i(blink_fast_i), .shutdown_i(shutdown_i), .glyph_sel_i(glyph_sel_i),
    .glyph_col_i(glyph_col_i), .rdata_o(rdata_o), .glyph_data_o(glyph_data_o), .scan_o(scan_o),
    .blink_o(blink_o));
`default_nettype wire

//--- verif/led_host_model.sv
// Host side model: register strobes and the multiplex clock source.
// Assumes a one-cycle strobe port sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output led_scan_pkg::reg_req_s req_o,
    output logic mux_clk_o
);
    int ph = 0;
    initial
    begin
        req_o = '0;
        mux_clk_o = 1'b0;
    end
    // Multiplex clock at 40/6 MHz
    always @(negedge clk_i)
    begin
        ph = (ph + 1) % 3;
        if (ph == 0)
            mux_clk_o <= ~mux_clk_o;
    end
    // One register write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge clk_i);
        req_o.wr <= 1'b0;
    endtask
    // One register read, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge clk_i);
        req_o.rd <= 1'b0;
        @(negedge clk_i);
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the LED scan and glyph control block.
// Assumes the host model drives the register port and multiplex clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic fast = 1'b1;
    logic shut = 1'b0;
    logic [4:0] sel = 5'h00;
    logic [2:0] col = 3'h0;
    led_scan_pkg::reg_req_s req;
    led_scan_pkg::scan_out_s scan;
    logic mux_clk;
    logic [7:0] rdata;
    logic [6:0] gdata;
    logic blink;
    logic prev;
    logic [7:0] q;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int on_cnt [4];
    int flips;
    int row_moves;
    logic [2:0] prow;
    int stp [4] = '{6, 15, 1, 10};
    logic [7:0] regs [5] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h04};
    logic [7:0] cols [5] = '{8'h42, 8'h61, 8'h51, 8'h49, 8'h46};
    initial forever #12.5 clk_i = ~clk_i;
    led_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req), .mux_clk_o(mux_clk));
    led_matrix_scan_font_control #(.BLINK_HALF_TICKS(20)) i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .req_i(req), .mux_clock_input_i(mux_clk), .blink_fast_i(fast),
        .shutdown_i(shut), .glyph_sel_i(sel), .glyph_col_i(col), .rdata_o(rdata), .glyph_data_o(gdata),
        .scan_o(scan), .blink_o(blink));
    task automatic end_sim();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Glyph lookup with one cycle latency
    task automatic gchk(input logic [4:0] s, input logic [2:0] c, input logic [6:0] e);
        @(negedge clk_i);
        sel = s;
        col = c;
        @(negedge clk_i);
        chk(32'(gdata), 32'(e));
    endtask
    // Lit cycles per digit and blink flips over one full frame
    task automatic measure(input int two_pair);
        on_cnt = '{0, 0, 0, 0};
        flips = 0;
        row_moves = 0;
        prev = blink;
        prow = scan.row;
        repeat (5600 * 6)
        begin
            @(negedge clk_i);
            for (int d = 0; d < 4; d++)
                on_cnt[d] += int'(scan.digit_on[d]);
            flips += int'(blink !== prev);
            prev = blink;
            // Row steps once per pair cycle
            row_moves += int'(scan.row !== prow);
            prow = scan.row;
        end
        for (int d = 0; d < 4; d++)
            chk(on_cnt[d], (d < 2 || two_pair) ? stp[d] * 25 * 7 * 6 * (two_pair ? 1 : 2) : 0);
        chk(flips, two_pair ? 280 : 140);
        chk(row_moves, two_pair ? 7 : 14);
    endtask
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        repeat (3) @(negedge clk_i);
        srst_i = 1'b0;
        foreach (regs[i])
        begin
            i_host.rd(regs[i], q);
            chk(32'(q), 32'h0);
        end
        i_host.wr(8'h01, 8'hf5);
        i_host.wr(8'h02, 8'h90);
        i_host.wr(8'h00, 8'hff);
        i_host.rd(8'h01, q);
        chk(32'(q), 32'hf5);
        for (int g = 0; g < 24; g++)
        begin
            i_host.wr(8'h05, 8'(8'h80 + 5 * g));
            i_host.wr(8'h05, 8'(g + 1));
        end
        for (int g = 0; g < 24; g++)
            gchk(5'(g), 3'h0, 7'(g + 1));
        gchk(5'd24, 3'h0, 7'h00);
        i_host.wr(8'h05, 8'h8a);
        foreach (cols[c])
            i_host.wr(8'h05, cols[c]);
        foreach (cols[c])
            gchk(5'd2, 3'(c), cols[c][6:0]);
        i_host.wr(8'h05, 8'h8a);
        foreach (cols[c])
        begin
            i_host.rd(8'h05, q);
            chk(32'(q), 32'(cols[c]));
        end
        i_host.wr(8'h05, 8'hf7);
        i_host.wr(8'h05, 8'h55);
        i_host.wr(8'h05, 8'h33);
        gchk(5'd23, 3'h4, 7'h55);
        i_host.wr(8'h05, 8'hff);
        i_host.rd(8'h05, q);
        chk(32'(q), 32'h33);
        i_host.wr(8'h05, 8'hf7);
        i_host.rd(8'h05, q);
        chk(32'(q), 32'h55);
        i_host.rd(8'h05, q);
        chk(32'(q), 32'h33);
        shut = 1'b1;
        i_host.wr(8'h07, 8'hfe);
        repeat (4) @(negedge clk_i);
        chk(32'(scan.all_lit), 32'h0);
        i_host.wr(8'h07, 8'h01);
        repeat (4) @(negedge clk_i);
        chk(32'(scan.all_lit), 32'h1);
        i_host.rd(8'h01, q);
        chk(32'(q), 32'hf5);
        i_host.wr(8'h07, 8'h00);
        shut = 1'b0;
        i_host.wr(8'h03, 8'h01);
        repeat (600) @(negedge clk_i);
        chk(32'(scan.all_lit), 32'h0);
        measure(1);
        fast = 1'b0;
        i_host.wr(8'h03, 8'h02);
        repeat (600) @(negedge clk_i);
        measure(0);
        end_sim();
    end
endmodule
`default_nettype wire
